// >>> rtl/irq_event_router.sv
// Master subsystem interrupt and DMA event routing with vector prioritisation
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Power-on and system reset requests win over every other exception at fixed level 3.
// - The nonmaskable event is taken at fixed level 2, just below the reset requests.
// - A memory, bus or usage fault that is disabled or unserviced escalates to hard fault at level 1.
// - With its DMA channel enabled, a peripheral request starts DMA and DMA completion raises its line.
// - With its DMA channel disabled, a peripheral request drives its interrupt line directly.
// - Watchdog, CAN, I2C and converter interrupts always bypass the DMA engine.
// - The NMI watchdog reaches only the reset block, never DMA or the interrupt controller.
// - Vectors 1 to 15 carry only exceptions that the core itself raises.
// - Peripheral interrupt bit n is presented as vector n plus 16, up to vector 107.
// - Both watchdog timers share peripheral bit 18, vector 34, table offset 0x88.
// - The core has two low-power states, light sleep and deep sleep.
module irq_event_router
   import irq_route_pkg::*;
#(
   parameter int unsigned N_IRQ = NUM_PERIPH_IRQ
) (
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire logic                      power_on_reset_request,
   input  wire logic                      system_reset_request,
   input  wire logic                      nonmaskable_event,
   input  wire logic [NUM_FAULTS-1:0]     fault_req,
   input  wire logic [NUM_FAULTS-1:0]     fault_enable,
   input  wire logic [NUM_CORE_MISC-1:0]  core_exc_req,
   input  wire logic [N_IRQ-1:0]          periph_req,
   input  wire logic [N_IRQ-1:0]          dma_chan_enable,
   input  wire logic [N_IRQ-1:0]          dma_done,
   input  wire logic                      watchdog0_irq,
   input  wire logic                      watchdog1_irq,
   input  wire logic                      nmi_watchdog_timeout,
   input  wire logic                      core_ack,
   input  wire logic                      sleep_request,
   input  wire logic                      sleep_deep,
   output logic [N_IRQ-1:0]               dma_start,
   output vec_out_s                       vec_out,
   output logic [N_IRQ-1:0]               irq_status,
   output power_state_e                   power_state,
   output logic                           reset_block_request
);

   logic [N_IRQ-1:0]   dma_start_ff,  nxt_dma_start;
   logic [N_IRQ-1:0]   irq_status_ff, nxt_irq_status;
   logic [NUM_VEC-1:0] pend_ff,       nxt_pend;
   vec_out_s           vec_ff,        nxt_vec;
   power_state_e       pwr_ff,        nxt_pwr;
   logic               nmi_wd_ff,     nxt_nmi_wd;
   logic [N_IRQ-1:0]   irq_line;
   logic [N_IRQ-1:0]   req_merged;
   logic [N_IRQ-1:0]   use_dma;
   logic               escalate;

   // Peripheral routing between DMA and direct interrupt lines
   always_comb begin
      req_merged = periph_req;
      req_merged[IRQ_WATCHDOG] = watchdog0_irq | watchdog1_irq;
      use_dma = dma_chan_enable & ~IRQ_NO_DMA[N_IRQ-1:0];
      nxt_dma_start = req_merged & use_dma & IRQ_ASSIGNED[N_IRQ-1:0];
      irq_line = ((req_merged & ~use_dma) | (dma_done & use_dma))
                 & IRQ_ASSIGNED[N_IRQ-1:0];
      nxt_irq_status = irq_line;
   end

   // Pending vectors: a new request wins over the acknowledge clear
   always_comb begin
      logic [NUM_VEC-1:0] set_v;
      logic [NUM_VEC-1:0] clr_v;
      set_v = '0;
      clr_v = '0;
      escalate = 1'b0;
      for (int k = 0; k < NUM_FAULTS; k++) begin
         if (fault_req[k] && (!fault_enable[k] || pend_ff[VEC_MEM_FAULT+k])) begin
            escalate = 1'b1;
         end else if (fault_req[k]) begin
            set_v[VEC_MEM_FAULT+k] = 1'b1;
         end
      end
      set_v[VEC_RESET] = power_on_reset_request | system_reset_request;
      set_v[VEC_NMI] = nonmaskable_event;
      set_v[VEC_HARD_FAULT] = escalate;
      set_v[VEC_CORE_LAST:VEC_CORE_MISC] = core_exc_req;
      set_v[PERIPH_VEC_BASE +: N_IRQ] = irq_line;
      if (core_ack && vec_ff.valid) begin
         clr_v[vec_ff.num] = 1'b1;
      end
      nxt_pend = (pend_ff & ~clr_v) | set_v;
   end

   // Lowest vector number wins; vectors 1..3 are the fixed levels
   always_comb begin
      logic [NUM_VEC-1:0] cand;
      cand = nxt_pend;
      nxt_vec = '0;
      for (int i = NUM_VEC - 1; i > 0; i--) begin
         if (cand[i]) begin
            nxt_vec.valid = 1'b1;
            nxt_vec.num = VEC_W'(i);
         end
      end
      nxt_vec.offset = OFFSET_W'({2'h0, nxt_vec.num} << OFFSET_SHIFT);
      if (!nxt_vec.valid) begin
         nxt_vec.level = LEVEL_PROG;
      end else if (nxt_vec.num == VEC_W'(VEC_RESET)) begin
         nxt_vec.level = LEVEL_RESET;
      end else if (nxt_vec.num == VEC_W'(VEC_NMI)) begin
         nxt_vec.level = LEVEL_NMI;
      end else if (nxt_vec.num == VEC_W'(VEC_HARD_FAULT)) begin
         nxt_vec.level = LEVEL_HARD;
      end else begin
         nxt_vec.level = LEVEL_PROG;
      end
   end

   // Low-power state: any pending vector wakes the core
   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PWR_RUN: begin
            if (sleep_request && !(|nxt_pend)) begin
               nxt_pwr = sleep_deep ? PWR_DEEP : PWR_LIGHT;
            end
         end
         PWR_LIGHT, PWR_DEEP: begin
            if (|nxt_pend) begin
               nxt_pwr = PWR_RUN;
            end
         end
         default: nxt_pwr = PWR_RUN;
      endcase
   end

   // NMI watchdog goes only to the reset block
   always_comb begin
      nxt_nmi_wd = nmi_watchdog_timeout;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dma_start_ff  <= '0;
         irq_status_ff <= '0;
         pend_ff       <= '0;
         vec_ff        <= '0;
         pwr_ff        <= PWR_RUN;
         nmi_wd_ff     <= 1'b0;
      end else begin
         dma_start_ff  <= nxt_dma_start;
         irq_status_ff <= nxt_irq_status;
         pend_ff       <= nxt_pend;
         vec_ff        <= nxt_vec;
         pwr_ff        <= nxt_pwr;
         nmi_wd_ff     <= nxt_nmi_wd;
      end
   end

   assign dma_start           = dma_start_ff;
   assign irq_status          = irq_status_ff;
   assign vec_out             = vec_ff;
   assign power_state         = pwr_ff;
   assign reset_block_request = nmi_wd_ff;

   chk_reset_top_level: assert property (@(posedge clock) disable iff (rst)
      (power_on_reset_request || system_reset_request) |=>
         (vec_out.valid && vec_out.num == 7'h01 && vec_out.level == 2'h3))
      else $error("reset request not presented at level 3");

   chk_nmi_level_two: assert property (@(posedge clock) disable iff (rst)
      (nonmaskable_event && !power_on_reset_request && !system_reset_request
       && !pend_ff[1]) |=> (vec_out.num == 7'h02 && vec_out.level == 2'h2))
      else $error("nonmaskable event not presented at level 2");

   chk_fault_escalation: assert property (@(posedge clock) disable iff (rst)
      (fault_req[0] && !fault_enable[0] && !pend_ff[4]) |=> (pend_ff[3] && !pend_ff[4]))
      else $error("disabled fault did not escalate");

   chk_hard_pending: assert property (@(posedge clock) disable iff (rst)
      (|(fault_req & ~fault_enable)) |=> pend_ff[3])
      else $error("hard fault not pending after disabled fault");

   chk_dma_start_path: assert property (@(posedge clock) disable iff (rst)
      (periph_req[0] && dma_chan_enable[0] && !dma_done[0]) |=> (dma_start[0] && !irq_status[0]))
      else $error("dma channel request not sent to dma");

   chk_direct_path: assert property (@(posedge clock) disable iff (rst)
      (periph_req[5] && !dma_chan_enable[5]) |=> (irq_status[5] && !dma_start[5]))
      else $error("direct request not routed to interrupt line");

   chk_bypass_dma: assert property (@(posedge clock) disable iff (rst)
      ##1 ((dma_start & IRQ_NO_DMA[N_IRQ-1:0]) == '0))
      else $error("dma start on a source without dma path");

   chk_watchdog_shared: assert property (@(posedge clock) disable iff (rst)
      ((watchdog0_irq || watchdog1_irq) && !pend_ff[1] && !pend_ff[2] && !pend_ff[3]
       && (pend_ff[33:4] == '0) && !power_on_reset_request && !system_reset_request
       && !nonmaskable_event && (fault_req == '0) && (core_exc_req == '0)
       && (periph_req[17:0] == '0) && (dma_done[17:0] == '0))
      |=> (vec_out.num == 7'h22 && vec_out.offset == 9'h088))
      else $error("watchdog not presented at vector 34");

   chk_nmi_wd_reset: assert property (@(posedge clock) disable iff (rst)
      nmi_watchdog_timeout |=> reset_block_request)
      else $error("nmi watchdog timeout not forwarded to reset block");

   chk_reserved_quiet: assert property (@(posedge clock) disable iff (rst)
      (irq_status & ~IRQ_ASSIGNED[N_IRQ-1:0]) == '0)
      else $error("reserved interrupt position asserted");

   chk_offset_scale: assert property (@(posedge clock) disable iff (rst)
      vec_out.valid |-> (vec_out.offset == {vec_out.num, 2'h0}))
      else $error("vector offset not four times vector number");

   chk_sleep_wake: assert property (@(posedge clock) disable iff (rst)
      (power_state != PWR_RUN && (|nxt_pend)) |=> power_state == PWR_RUN)
      else $error("pending vector did not wake the core");

endmodule

`default_nettype wire

// >>> rtl/irq_route_pkg.sv
// Constants and carrier types for the master interrupt and event router
package irq_route_pkg;
   localparam int unsigned NUM_PERIPH_IRQ  = 92;
   localparam int unsigned PERIPH_VEC_BASE = 16;
   localparam int unsigned NUM_VEC         = 108;
   localparam int unsigned VEC_W           = 7;
   localparam int unsigned OFFSET_W        = 9;
   localparam int unsigned OFFSET_SHIFT    = 2;
   localparam int unsigned VEC_RESET       = 1;
   localparam int unsigned VEC_NMI         = 2;
   localparam int unsigned VEC_HARD_FAULT  = 3;
   localparam int unsigned VEC_MEM_FAULT   = 4;
   localparam int unsigned VEC_CORE_LAST   = 15;
   localparam int unsigned VEC_CORE_MISC   = 11;
   localparam int unsigned NUM_FAULTS      = 3;
   localparam int unsigned NUM_CORE_MISC   = 5;
   localparam int unsigned IRQ_WATCHDOG    = 18;
   localparam logic [1:0]  LEVEL_RESET     = 2'h3;
   localparam logic [1:0]  LEVEL_NMI       = 2'h2;
   localparam logic [1:0]  LEVEL_HARD      = 2'h1;
   localparam logic [1:0]  LEVEL_PROG      = 2'h0;
   // Assigned peripheral interrupt positions; all others are reserved
   localparam logic [NUM_PERIPH_IRQ-1:0] IRQ_ASSIGNED =
      92'h70FFF0F_1E60D43F_D1FC01FF;
   // Sources with no DMA path: watchdogs, CAN, I2C, converter lines
   localparam logic [NUM_PERIPH_IRQ-1:0] IRQ_NO_DMA =
      92'h000FF0F_00000020_00040100;

   typedef enum logic [1:0] {
      PWR_RUN   = 2'h0,
      PWR_LIGHT = 2'h1,
      PWR_DEEP  = 2'h3
   } power_state_e;

   typedef struct packed {
      logic                valid;
      logic [1:0]          level;
      logic [VEC_W-1:0]    num;
      logic [OFFSET_W-1:0] offset;
   } vec_out_s;
endpackage

// >>> dv/core_model.sv
// Processor core model that takes each presented vector
`timescale 1ns/1ps
`default_nettype none
module core_model
   import irq_route_pkg::*;
(
   input  wire logic     clock,
   input  wire logic     rst,
   input  wire logic     slow,
   input  wire vec_out_s vec_out,
   output var logic      core_ack
);
   int gap = 0;
   initial core_ack = 1'b0;
   // Gap lets the next vector settle after a take
   always @(posedge clock) begin
      #1;
      core_ack = 1'b0;
      if (gap > 0) gap--;
      else if (!rst && vec_out.valid === 1'b1) begin
         core_ack = 1'b1;
         gap = slow ? 6 : 2;
      end
   end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the interrupt and event router
`timescale 1ns/1ps
`default_nettype none
module tb;
   import irq_route_pkg::*;
   localparam int N = NUM_PERIPH_IRQ;
   logic clock = 0, rst = 1, slow = 0, core_ack;
   logic power_on_reset_request = 0, system_reset_request = 0, nonmaskable_event = 0;
   logic [2:0] fault_req = 0, fault_enable = 0;
   logic [4:0] core_exc_req = 0;
   logic [N-1:0] periph_req = 0, dma_chan_enable = 0, dma_done = 0, dma_start, irq_status;
   logic watchdog0_irq = 0, watchdog1_irq = 0, nmi_watchdog_timeout = 0;
   logic sleep_request = 0, sleep_deep = 0, reset_block_request;
   vec_out_s vec_out;
   power_state_e power_state;
   logic [8:0] exp_q[$];
   logic [8:0] e;
   int fails = 0, check_count = 0, n;
   irq_event_router uut (.clock, .rst, .power_on_reset_request, .system_reset_request,
      .nonmaskable_event, .fault_req, .fault_enable, .core_exc_req, .periph_req,
      .dma_chan_enable, .dma_done, .watchdog0_irq, .watchdog1_irq, .nmi_watchdog_timeout,
      .core_ack, .sleep_request, .sleep_deep, .dma_start, .vec_out, .irq_status,
      .power_state, .reset_block_request);
   core_model core (.clock, .rst, .slow, .vec_out, .core_ack);
   always #20 clock = ~clock;
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge clock);
      #1;
   endtask
   task automatic want(logic [1:0] lv, int unsigned v);
      exp_q.push_back({lv, v[6:0]});
   endtask
   task automatic drain(string name);
      for (int i = 0; i < 80 && exp_q.size() != 0; i++) tick();
      repeat (8) tick();
      check("pending notes", exp_q.size(), 0);
      $display("Test %s done", name);
   endtask
   task automatic complete_run();
      $display("Counts: %0d checks, %0d fails", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Each take is compared with the oldest note
   always @(posedge clock) if (!rst && core_ack === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 9'h1FF;
      check("vector valid", vec_out.valid, 1);
      check("vector level and num", {vec_out.level, vec_out.num}, e);
      check("vector offset", vec_out.offset, {e[6:0], 2'b00});
   end
   initial begin
      #(40 * 4000);
      fails++;
      complete_run();
   end
   initial begin
      void'($urandom(95484));
      repeat (20) @(posedge clock);
      #1 rst = 0;
      tick();
      {power_on_reset_request, nonmaskable_event, fault_req} = 5'h19;
      want(LEVEL_RESET, VEC_RESET);
      want(LEVEL_NMI, VEC_NMI);
      want(LEVEL_HARD, VEC_HARD_FAULT);
      tick();
      {power_on_reset_request, nonmaskable_event, fault_req} = 5'h00;
      drain("fixed levels");
      fault_enable = 3'h7;
      {system_reset_request, fault_req[1], core_exc_req[0]} = 3'h7;
      want(LEVEL_RESET, VEC_RESET);
      want(LEVEL_PROG, VEC_MEM_FAULT + 1);
      want(LEVEL_PROG, VEC_CORE_MISC);
      tick();
      {system_reset_request, fault_req[1], core_exc_req[0]} = 3'h0;
      drain("core exceptions");
      // Same fault again while still pending escalates
      fault_req[2] = 1;
      want(LEVEL_PROG, VEC_MEM_FAULT + 2);
      want(LEVEL_HARD, VEC_HARD_FAULT);
      repeat (2) tick();
      fault_req[2] = 0;
      drain("fault recurrence");
      for (int i = 0; i < 8; i++) begin
         do n = $urandom % N; while (!IRQ_ASSIGNED[n] || n == IRQ_WATCHDOG);
         periph_req[n] = 1;
         want(LEVEL_PROG, n + PERIPH_VEC_BASE);
         tick();
         check("direct status", irq_status[n], 1);
         periph_req[n] = 0;
         drain("direct line");
      end
      {periph_req[9], periph_req[IRQ_WATCHDOG]} = 2'h3;
      tick();
      check("reserved status", irq_status[9], 0);
      check("bit 18 ignored", irq_status[IRQ_WATCHDOG], 0);
      {periph_req[9], periph_req[IRQ_WATCHDOG]} = 2'h0;
      drain("reserved line");
      slow = 1;
      {dma_chan_enable[0], periph_req[0]} = 2'h3;
      tick();
      check("dma start", dma_start[0], 1);
      periph_req[0] = 0;
      tick();
      dma_done[0] = 1;
      want(LEVEL_PROG, PERIPH_VEC_BASE);
      tick();
      dma_done[0] = 0;
      drain("dma path");
      {dma_chan_enable[72], periph_req[72]} = 2'h3;
      want(LEVEL_PROG, 88);
      tick();
      check("no dma start", dma_start[72], 0);
      check("bypass status", irq_status[72], 1);
      periph_req[72] = 0;
      drain("dma bypass");
      watchdog1_irq = 1;
      want(LEVEL_PROG, 34);
      tick();
      check("watchdog status", irq_status[IRQ_WATCHDOG], 1);
      watchdog1_irq = 0;
      drain("watchdog line");
      watchdog0_irq = 1;
      want(LEVEL_PROG, 34);
      tick();
      check("watchdog0 status", irq_status[IRQ_WATCHDOG], 1);
      watchdog0_irq = 0;
      drain("second watchdog");
      nmi_watchdog_timeout = 1;
      tick();
      check("reset block request", reset_block_request, 1);
      nmi_watchdog_timeout = 0;
      drain("nmi watchdog");
      {sleep_request, sleep_deep} = 2'h3;
      tick();
      check("deep sleep", power_state, PWR_DEEP);
      {sleep_request, sleep_deep, periph_req[5]} = 3'h1;
      want(LEVEL_PROG, 21);
      tick();
      periph_req[5] = 0;
      tick();
      check("wake", power_state, PWR_RUN);
      drain("deep sleep");
      sleep_request = 1;
      tick();
      check("light sleep", power_state, PWR_LIGHT);
      sleep_request = 0;
      drain("light sleep");
      complete_run();
   end
endmodule
`default_nettype wire
